// ===== verilog/ffp_defs.vh
// constants of the 802.15.4 frame framer and header parser
`ifndef FFP_DEFS_VH
`define FFP_DEFS_VH
`define FFP_SFD            8'ha7
`define FFP_ZERO_OCTET     8'h00
`define FFP_PREAMBLE_CNT   3'h4
`define FFP_SHR_OCTETS     3'h5
`define FFP_LEN_MASK       8'h7f
`define FFP_SHR_TIME_US    160
`define FFP_CLK_MHZ        100
`define FFP_ACK_TIME_US    192
// frame control field positions
`define FFP_FT_MSB         2
`define FFP_FT_LSB         0
`define FFP_PEND_BIT       4
`define FFP_AREQ_BIT       5
`define FFP_INTRA_BIT      6
`define FFP_DM_MSB         11
`define FFP_DM_LSB         10
`define FFP_VER_MSB        13
`define FFP_VER_LSB        12
`define FFP_SM_MSB         15
`define FFP_SM_LSB         14
// frame types
`define FFP_FT_BEACON      3'h0
`define FFP_FT_DATA        3'h1
`define FFP_FT_ACK         3'h2
`define FFP_FT_CMD         3'h3
// addressing modes
`define FFP_AM_NONE        2'h0
`define FFP_AM_SHORT       2'h2
`define FFP_AM_EXT         2'h3
// length classes
`define FFP_LC_RSVD        2'h0
`define FFP_LC_ACK         2'h1
`define FFP_LC_MPDU        2'h2
`define FFP_LEN_ACK        7'h05
`define FFP_LEN_MPDU_MIN   7'h09
// header byte offsets and sizes
`define FFP_IDX_FCF_LO     7'h00
`define FFP_IDX_FCF_HI     7'h01
`define FFP_IDX_SEQ        7'h02
`define FFP_IDX_DPAN_LO    7'h03
`define FFP_IDX_DPAN_HI    7'h04
`define FFP_IDX_DADR_LO    7'h05
`define FFP_IDX_DADR_HI    7'h06
`define FFP_MHR_BASE       7'h03
`define FFP_PAN_BYTES      7'h02
`define FFP_SHORT_BYTES    7'h02
`define FFP_EXT_BYTES      7'h08
`define FFP_BCAST_ADDR     16'hffff
`define FFP_CMD_DATA_REQ   8'h04
`define FFP_FCS_LEFT       7'h02
`endif

// ===== verilog/ffp_frame_parser.v
// framer and frame control parser of the 2.4 GHz transceiver
`timescale 1ns/1ps
`include "ffp_defs.vh"
// How it works
// - transmit prepends four zero preamble octets and start delimiter a7
// - header lasts 160 us; buffer octets may arrive later, stalling transmit
// - receive hunts preamble and delimiter; next octet is the length
// - low 7 length bits are length; top bit reserved, sent as zero
// - length octet written to buffer first with its top bit cleared
// - receive start interrupt pulses once a valid length octet arrives
// - payload 0 to 127 octets; last two octets flagged as check sequence
// - zero length frames are dropped without any interrupt
// - length classified: 5 ack, 9 and above mpdu, others reserved
// - frame control is sixteen bits from first two payload octets
// - frame control bits 2:0 decoded as frame type
// - filter passes frame types three or below
// - reserved types pass when reserved type upload bit is set
// - frame type filtering is active only in auto acknowledge receive mode; no address check
// - generated ack sets pending from ack pending set bit when acking a data request
// - ack request on unicast data or command triggers acknowledgement
// - auto retry transmit waits for ack only if ack request set
// - intra pan bit with both addresses drops the source pan field
// - addressing modes decoded: none, reserved, short, extended
// - present destination starts with pan id, then its address
// - frame version decoded; version select limits acknowledged versions
// - sequence number copied from frame into its acknowledgement
module ffp_frame_parser #(
  parameter SHR_CYCLES = `FFP_SHR_TIME_US * `FFP_CLK_MHZ
) (
  input  wire       i_clk,
  input  wire       i_rstn,
  input  wire       i_auto_ack_receive_mode,
  input  wire       i_auto_retry_transmit_mode,
  input  wire       i_reserved_type_upload_bit,
  input  wire       i_ack_pending_set_bit,
  input  wire [1:0] i_version_ack_select,
  input  wire       i_tx_start,
  input  wire [7:0] i_fb_rd_data,
  input  wire       i_fb_rd_valid,
  output wire       o_fb_rd_req,
  input  wire       i_air_ready,
  output reg  [7:0] o_air_data,
  output reg        o_air_valid,
  output reg        o_tx_busy,
  output reg        o_tx_end,
  output reg        o_tx_wait_ack,
  input  wire [7:0] i_rx_data,
  input  wire       i_rx_valid,
  output reg  [7:0] o_fb_wr_data,
  output reg        o_fb_wr_valid,
  output reg        o_fb_wr_fcs,
  output reg        o_receive_start_irq,
  output reg  [1:0] o_rx_len_class,
  output reg  [2:0] o_rx_frame_type,
  output reg  [1:0] o_rx_version,
  output reg  [1:0] o_rx_dst_mode,
  output reg  [1:0] o_rx_src_mode,
  output reg        o_rx_intra_pan,
  output reg        o_rx_ack_request,
  output reg        o_rx_end,
  output reg        o_rx_filter_pass,
  output reg        o_ack_send,
  output reg [15:0] o_ack_fcf,
  output reg  [7:0] o_ack_seq
);

  // =========================================================
  // constants
  localparam [31:0] SHR_OCTET_CYCLES = SHR_CYCLES / `FFP_SHR_OCTETS;
  localparam [31:0] ACK_CYCLES       = `FFP_ACK_TIME_US * `FFP_CLK_MHZ;
  localparam [3:0] TX_IDLE = 4'h1;
  localparam [3:0] TX_SHR  = 4'h2;
  localparam [3:0] TX_LEN  = 4'h4;
  localparam [3:0] TX_BODY = 4'h8;
  localparam [2:0] RX_HUNT = 3'h1;
  localparam [2:0] RX_LEN  = 3'h2;
  localparam [2:0] RX_BODY = 3'h4;

  // =========================================================
  // functions
  // octets of one address field for a mode
  function [6:0] addr_bytes;
    input [1:0] mode;
    begin
      case (mode)
        `FFP_AM_SHORT: addr_bytes = `FFP_SHORT_BYTES;
        `FFP_AM_EXT:   addr_bytes = `FFP_EXT_BYTES;
        default:       addr_bytes = 7'h00;
      endcase
    end
  endfunction

  // offset of the first octet behind the addressing fields
  function [6:0] mhr_len;
    input [1:0] dm;
    input [1:0] sm;
    input       intra;
    reg   [6:0] n;
    begin
      n = `FFP_MHR_BASE;
      if (addr_bytes(dm) != 7'h00) begin
        n = n + `FFP_PAN_BYTES + addr_bytes(dm);
      end
      if (addr_bytes(sm) != 7'h00) begin
        if (!(intra && addr_bytes(dm) != 7'h00)) begin
          n = n + `FFP_PAN_BYTES;
        end
        n = n + addr_bytes(sm);
      end
      mhr_len = n;
    end
  endfunction

  // =========================================================
  // transmit framer
  reg [3:0]  tx_state_r;
  reg [31:0] tx_cnt_r;
  reg [2:0]  tx_shr_idx_r;
  reg [6:0]  tx_left_r;
  reg        tx_first_r;
  reg        tx_areq_r;
  wire       tx_take;
  wire       tx_shr_tick;

  // buffer octet moves only when both buffer and air can go
  assign tx_take     = (tx_state_r == TX_LEN || tx_state_r == TX_BODY) &&
                       i_fb_rd_valid && i_air_ready;
  assign o_fb_rd_req = tx_take;
  assign tx_shr_tick = (tx_cnt_r == SHR_OCTET_CYCLES - 32'h1);

  // header pacing, length and payload streaming
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_state_r    <= TX_IDLE;
      tx_cnt_r      <= 32'h0;
      tx_shr_idx_r  <= 3'h0;
      tx_left_r     <= 7'h00;
      tx_first_r    <= 1'b0;
      tx_areq_r     <= 1'b0;
      o_air_data    <= 8'h00;
      o_air_valid   <= 1'b0;
      o_tx_busy     <= 1'b0;
      o_tx_end      <= 1'b0;
      o_tx_wait_ack <= 1'b0;
    end else begin
      o_air_valid   <= 1'b0;
      o_tx_end      <= 1'b0;
      o_tx_wait_ack <= 1'b0;
      case (tx_state_r)
        TX_IDLE: begin
          if (i_tx_start) begin
            tx_state_r   <= TX_SHR;
            tx_cnt_r     <= 32'h0;
            tx_shr_idx_r <= 3'h0;
            tx_areq_r    <= 1'b0;
            o_tx_busy    <= 1'b1;
          end
        end
        TX_SHR: begin
          tx_cnt_r <= tx_shr_tick ? 32'h0 : tx_cnt_r + 32'h1;
          if (tx_shr_tick) begin
            o_air_valid  <= 1'b1;
            o_air_data   <= (tx_shr_idx_r == `FFP_PREAMBLE_CNT) ?
                            `FFP_SFD : `FFP_ZERO_OCTET;
            tx_shr_idx_r <= tx_shr_idx_r + 3'h1;
            if (tx_shr_idx_r == `FFP_SHR_OCTETS - 3'h1) begin
              tx_state_r <= TX_LEN;
            end
          end
        end
        TX_LEN: begin
          if (tx_take) begin
            o_air_valid <= 1'b1;
            o_air_data  <= i_fb_rd_data & `FFP_LEN_MASK;
            tx_left_r   <= i_fb_rd_data[6:0];
            tx_first_r  <= 1'b1;
            if (i_fb_rd_data[6:0] == 7'h00) begin
              tx_state_r <= TX_IDLE;
              o_tx_busy  <= 1'b0;
              o_tx_end   <= 1'b1;
            end else begin
              tx_state_r <= TX_BODY;
            end
          end
        end
        TX_BODY: begin
          if (tx_take) begin
            o_air_valid <= 1'b1;
            o_air_data  <= i_fb_rd_data;
            tx_first_r  <= 1'b0;
            tx_left_r   <= tx_left_r - 7'h01;
            if (tx_first_r) begin
              tx_areq_r <= i_fb_rd_data[`FFP_AREQ_BIT];
            end
            if (tx_left_r == 7'h01) begin
              tx_state_r    <= TX_IDLE;
              o_tx_busy     <= 1'b0;
              o_tx_end      <= 1'b1;
              o_tx_wait_ack <= i_auto_retry_transmit_mode &&
                (tx_first_r ? i_fb_rd_data[`FFP_AREQ_BIT] : tx_areq_r);
            end
          end
        end
        default: begin
          tx_state_r <= TX_IDLE;
          o_tx_busy  <= 1'b0;
        end
      endcase
    end
  end

  // =========================================================
  // receive deframer and header parser
  reg [2:0]  rx_state_r;
  reg [2:0]  rx_zero_r;
  reg [6:0]  rx_left_r;
  reg [6:0]  rx_idx_r;
  reg [15:0] rx_fcf_r;
  reg [7:0]  rx_seq_r;
  reg [15:0] rx_daddr_r;
  reg        rx_datareq_r;
  wire [15:0] fcf_now;
  wire [2:0]  ft_now;
  wire        type_ok;
  wire        ver_ok;
  wire        unicast;
  wire        data_or_cmd;

  // decode uses the high octet the cycle it arrives
  assign fcf_now = (rx_idx_r == `FFP_IDX_FCF_HI) ?
                   {i_rx_data, rx_fcf_r[7:0]} : rx_fcf_r;
  assign ft_now  = rx_fcf_r[`FFP_FT_MSB:`FFP_FT_LSB];
  assign type_ok = (ft_now <= `FFP_FT_CMD) || i_reserved_type_upload_bit;
  assign ver_ok  = rx_fcf_r[`FFP_VER_MSB:`FFP_VER_LSB] <= i_version_ack_select;
  assign unicast = !(rx_fcf_r[`FFP_DM_MSB:`FFP_DM_LSB] == `FFP_AM_SHORT &&
                     rx_daddr_r == `FFP_BCAST_ADDR);
  assign data_or_cmd = (ft_now == `FFP_FT_DATA) || (ft_now == `FFP_FT_CMD);

  // octet stream: hunt, length, body with field capture
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_state_r          <= RX_HUNT;
      rx_zero_r           <= 3'h0;
      rx_left_r           <= 7'h00;
      rx_idx_r            <= 7'h00;
      rx_fcf_r            <= 16'h0000;
      rx_seq_r            <= 8'h00;
      rx_daddr_r          <= 16'h0000;
      rx_datareq_r        <= 1'b0;
      o_fb_wr_data        <= 8'h00;
      o_fb_wr_valid       <= 1'b0;
      o_fb_wr_fcs         <= 1'b0;
      o_receive_start_irq <= 1'b0;
      o_rx_len_class      <= `FFP_LC_RSVD;
      o_rx_frame_type     <= 3'h0;
      o_rx_version        <= 2'h0;
      o_rx_dst_mode       <= 2'h0;
      o_rx_src_mode       <= 2'h0;
      o_rx_intra_pan      <= 1'b0;
      o_rx_ack_request    <= 1'b0;
      o_rx_end            <= 1'b0;
      o_rx_filter_pass    <= 1'b0;
      o_ack_send          <= 1'b0;
      o_ack_fcf           <= 16'h0000;
      o_ack_seq           <= 8'h00;
    end else begin
      o_fb_wr_valid       <= 1'b0;
      o_fb_wr_fcs         <= 1'b0;
      o_receive_start_irq <= 1'b0;
      o_rx_end            <= 1'b0;
      o_ack_send          <= 1'b0;
      if (i_rx_valid) begin
        case (rx_state_r)
          RX_HUNT: begin
            if (i_rx_data == `FFP_ZERO_OCTET) begin
              rx_zero_r <= (rx_zero_r == `FFP_PREAMBLE_CNT) ?
                           rx_zero_r : rx_zero_r + 3'h1;
            end else if (i_rx_data == `FFP_SFD &&
                         rx_zero_r == `FFP_PREAMBLE_CNT) begin
              rx_state_r <= RX_LEN;
              rx_zero_r  <= 3'h0;
            end else begin
              rx_zero_r <= 3'h0;
            end
          end
          RX_LEN: begin
            o_fb_wr_valid <= 1'b1;
            o_fb_wr_data  <= i_rx_data & `FFP_LEN_MASK;
            rx_left_r     <= i_rx_data[6:0];
            rx_idx_r      <= 7'h00;
            rx_datareq_r  <= 1'b0;
            rx_fcf_r      <= 16'h0000;
            rx_daddr_r    <= 16'h0000;
            if (i_rx_data[6:0] == 7'h00) begin
              rx_state_r <= RX_HUNT;
            end else begin
              rx_state_r          <= RX_BODY;
              o_receive_start_irq <= 1'b1;
            end
            if (i_rx_data[6:0] == `FFP_LEN_ACK) begin
              o_rx_len_class <= `FFP_LC_ACK;
            end else if (i_rx_data[6:0] >= `FFP_LEN_MPDU_MIN) begin
              o_rx_len_class <= `FFP_LC_MPDU;
            end else begin
              o_rx_len_class <= `FFP_LC_RSVD;
            end
          end
          RX_BODY: begin
            o_fb_wr_valid <= 1'b1;
            o_fb_wr_data  <= i_rx_data;
            o_fb_wr_fcs   <= (rx_left_r <= `FFP_FCS_LEFT);
            rx_idx_r      <= rx_idx_r + 7'h01;
            rx_left_r     <= rx_left_r - 7'h01;
            case (rx_idx_r)
              `FFP_IDX_FCF_LO: rx_fcf_r[7:0]  <= i_rx_data;
              `FFP_IDX_FCF_HI: rx_fcf_r[15:8] <= i_rx_data;
              `FFP_IDX_SEQ:    rx_seq_r       <= i_rx_data;
              default: begin
              end
            endcase
            if (rx_fcf_r[`FFP_DM_MSB:`FFP_DM_LSB] == `FFP_AM_SHORT) begin
              if (rx_idx_r == `FFP_IDX_DADR_LO) begin
                rx_daddr_r[7:0] <= i_rx_data;
              end
              if (rx_idx_r == `FFP_IDX_DADR_HI) begin
                rx_daddr_r[15:8] <= i_rx_data;
              end
            end
            // command id right behind the addressing fields
            if (rx_idx_r > `FFP_IDX_FCF_HI && ft_now == `FFP_FT_CMD &&
                rx_idx_r == mhr_len(rx_fcf_r[`FFP_DM_MSB:`FFP_DM_LSB],
                                    rx_fcf_r[`FFP_SM_MSB:`FFP_SM_LSB],
                                    rx_fcf_r[`FFP_INTRA_BIT])) begin
              rx_datareq_r <= (i_rx_data == `FFP_CMD_DATA_REQ);
            end
            if (rx_idx_r == `FFP_IDX_FCF_HI) begin
              o_rx_frame_type  <= fcf_now[`FFP_FT_MSB:`FFP_FT_LSB];
              o_rx_version     <= fcf_now[`FFP_VER_MSB:`FFP_VER_LSB];
              o_rx_dst_mode    <= fcf_now[`FFP_DM_MSB:`FFP_DM_LSB];
              o_rx_src_mode    <= fcf_now[`FFP_SM_MSB:`FFP_SM_LSB];
              o_rx_intra_pan   <= fcf_now[`FFP_INTRA_BIT];
              o_rx_ack_request <= fcf_now[`FFP_AREQ_BIT];
            end
            if (rx_left_r == 7'h01) begin
              rx_state_r       <= RX_HUNT;
              o_rx_end         <= 1'b1;
              o_rx_filter_pass <= i_auto_ack_receive_mode ? type_ok : 1'b1;
              o_ack_seq        <= rx_seq_r;
              o_ack_fcf        <= {13'h0000, `FFP_FT_ACK} |
                                  ((rx_datareq_r && i_ack_pending_set_bit) ?
                                   16'h0010 : 16'h0000);
              o_ack_send       <= i_auto_ack_receive_mode && type_ok && ver_ok &&
                                  rx_fcf_r[`FFP_AREQ_BIT] && data_or_cmd &&
                                  unicast;
            end
          end
          default: begin
            rx_state_r <= RX_HUNT;
          end
        endcase
      end
    end
  end

endmodule

// ===== bench/ffp_air_node.sv
// remote radio node model: sends framed octets and collects transmitted ones
`timescale 1ns/1ps
module ffp_air_node (
  input  wire       i_clk,
  input  wire [7:0] i_air_data,
  input  wire       i_air_valid,
  output reg  [7:0] o_rx_data,
  output reg        o_rx_valid,
  output reg        o_air_ready
);
  logic [7:0] txq [$];
  logic       slow;
  logic [7:0] cyc;
  initial begin
    o_rx_data = 8'hff;
    o_rx_valid = 1'b0;
    o_air_ready = 1'b1;
    slow = 1'b0;
    cyc = 8'h00;
  end
  // collect every octet put on the air
  always @(posedge i_clk) begin
    if (i_air_valid) txq.push_back(i_air_data);
  end
  // when told to be slow, accept only every other cycle
  always @(negedge i_clk) begin
    cyc <= cyc + 8'h01;
    o_air_ready <= !slow || cyc[0];
  end
  // four zero octets, delimiter, then the frame from its length octet on
  task send(input logic [7:0] f [$]);
    int i;
    for (i = 0; i < f.size() + 5; i++) begin
      @(negedge i_clk);
      o_rx_valid = 1'b1;
      o_rx_data = (i < 4) ? 8'h00 : (i == 4) ? 8'ha7 : f[i-5];
    end
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data;
  endtask
endmodule

// ===== bench/ffp_frame_parser_chk.sv
// port checker for the framer and frame control parser
`timescale 1ns/1ps
module ffp_frame_parser_chk #(
  parameter SHR_CYCLES = 16000
) (
  input wire        i_clk,
  input wire        i_rstn,
  input wire        i_auto_ack_receive_mode,
  input wire        i_auto_retry_transmit_mode,
  input wire        i_reserved_type_upload_bit,
  input wire        i_ack_pending_set_bit,
  input wire [1:0]  i_version_ack_select,
  input wire        i_fb_rd_valid,
  input wire        i_air_ready,
  input wire        o_fb_rd_req,
  input wire [7:0]  o_air_data,
  input wire        o_air_valid,
  input wire        o_tx_busy,
  input wire        o_tx_end,
  input wire        o_tx_wait_ack,
  input wire [7:0]  o_fb_wr_data,
  input wire        o_fb_wr_valid,
  input wire        o_fb_wr_fcs,
  input wire        o_receive_start_irq,
  input wire [2:0]  o_rx_frame_type,
  input wire [1:0]  o_rx_version,
  input wire        o_rx_ack_request,
  input wire        o_rx_end,
  input wire        o_rx_filter_pass,
  input wire        o_ack_send,
  input wire [15:0] o_ack_fcf
);
  localparam int P_GAP = SHR_CYCLES / 5;
  logic [7:0]  cnt_r;
  logic [15:0] gap_r;
  // octet index within a transmission and cycles since the last octet
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 8'h00;
      gap_r <= 16'h0000;
    end else begin
      gap_r <= o_air_valid ? 16'h0000 : gap_r + 16'h0001;
      if (o_air_valid) cnt_r <= o_tx_end ? 8'h00 : cnt_r + 8'h01;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_pre_zero: assert property (o_air_valid && cnt_r < 8'h04 |-> o_air_data == 8'h00)
    else $error("preamble octet not zero");
  a_sfd_fifth: assert property (o_air_valid && cnt_r == 8'h04 |-> o_air_data == 8'ha7)
    else $error("fifth octet not delimiter");
  a_pre_gap: assert property (o_air_valid && cnt_r != 0 && cnt_r <= 8'h04
    |-> gap_r == P_GAP - 1) else $error("header octet spacing wrong");
  a_len_top: assert property (o_air_valid && cnt_r == 8'h05 |-> !o_air_data[7])
    else $error("length top bit sent set");
  a_rd_cause: assert property (o_fb_rd_req |-> i_fb_rd_valid && i_air_ready
    && o_tx_busy ##1 o_air_valid) else $error("buffer read without data, ready or send");
  a_wait_end: assert property (o_tx_wait_ack |-> o_tx_end && i_auto_retry_transmit_mode)
    else $error("ack wait outside frame end");
  a_irq_len: assert property (o_receive_start_irq |-> o_fb_wr_valid
    && o_fb_wr_data != 8'h00 && !o_fb_wr_data[7]) else $error("start irq on bad length");
  a_ack_cause: assert property (o_ack_send |-> o_rx_end && i_auto_ack_receive_mode
    && o_rx_ack_request && o_rx_filter_pass && (o_rx_frame_type == 3'h1
    || o_rx_frame_type == 3'h3) && o_rx_version <= i_version_ack_select)
    else $error("ack sent without cause");
  a_filter_rule: assert property (o_rx_end |-> o_rx_filter_pass == (!i_auto_ack_receive_mode
    || o_rx_frame_type <= 3'h3 || i_reserved_type_upload_bit))
    else $error("filter verdict wrong");
  a_ack_fields: assert property (o_ack_send |-> o_ack_fcf[3:0] == 4'h2
    && o_ack_fcf[15:5] == 11'h000 && (!o_ack_fcf[4] || i_ack_pending_set_bit))
    else $error("generated ack control field wrong");
  a_fcs_write: assert property (o_fb_wr_fcs |-> o_fb_wr_valid)
    else $error("check octet flag without write");
endmodule
bind ffp_frame_parser ffp_frame_parser_chk #(.SHR_CYCLES(SHR_CYCLES)) chk_u (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_auto_ack_receive_mode(i_auto_ack_receive_mode),
  .i_auto_retry_transmit_mode(i_auto_retry_transmit_mode),
  .i_reserved_type_upload_bit(i_reserved_type_upload_bit),
  .i_ack_pending_set_bit(i_ack_pending_set_bit), .i_version_ack_select(i_version_ack_select),
  .i_fb_rd_valid(i_fb_rd_valid), .i_air_ready(i_air_ready), .o_fb_rd_req(o_fb_rd_req),
  .o_air_data(o_air_data), .o_air_valid(o_air_valid), .o_tx_busy(o_tx_busy),
  .o_tx_end(o_tx_end), .o_tx_wait_ack(o_tx_wait_ack), .o_fb_wr_data(o_fb_wr_data),
  .o_fb_wr_valid(o_fb_wr_valid), .o_fb_wr_fcs(o_fb_wr_fcs),
  .o_receive_start_irq(o_receive_start_irq), .o_rx_frame_type(o_rx_frame_type),
  .o_rx_version(o_rx_version), .o_rx_ack_request(o_rx_ack_request), .o_rx_end(o_rx_end),
  .o_rx_filter_pass(o_rx_filter_pass), .o_ack_send(o_ack_send), .o_ack_fcf(o_ack_fcf));

// ===== bench/tb_ffp_frame_parser.sv
// self-checking bench of the framer and frame control parser
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_ffp_frame_parser;
  logic        clk, rstn, ama, arm, upl, pend, start, fb_v, took, eack, epass, wa;
  logic [1:0]  sel;
  logic [7:0]  fb_d, irq_d;
  logic [15:0] fcf, da;
  logic [37:0] rows [10];
  logic [7:0]  fbq [$];
  logic [7:0]  f [$];
  logic [7:0]  exp_tx [$];
  wire  [7:0]  air_d, rx_d, wr_d, ack_seq;
  wire  [1:0]  cls, ver, dm, sm;
  wire  [2:0]  ftype;
  wire  [15:0] ack_fcf;
  wire         rd_req, air_v, air_rdy, busy, tx_end, wait_ack, rx_v, wr_v, wr_fcs;
  wire         irq, intra, areq, rx_end, pass, ack;
  int          num_errors, check_count, cyc_n, irq_n, fcs_n, te_n, ack_n, r, k, t0, a0;
  int          wr_n, re_n, w0, e0;
  ffp_frame_parser #(.SHR_CYCLES(50)) dut_u (
    .i_clk(clk), .i_rstn(rstn), .i_auto_ack_receive_mode(ama),
    .i_auto_retry_transmit_mode(arm), .i_reserved_type_upload_bit(upl),
    .i_ack_pending_set_bit(pend), .i_version_ack_select(sel), .i_tx_start(start),
    .i_fb_rd_data(fb_d), .i_fb_rd_valid(fb_v), .o_fb_rd_req(rd_req), .i_air_ready(air_rdy),
    .o_air_data(air_d), .o_air_valid(air_v), .o_tx_busy(busy), .o_tx_end(tx_end),
    .o_tx_wait_ack(wait_ack), .i_rx_data(rx_d), .i_rx_valid(rx_v), .o_fb_wr_data(wr_d),
    .o_fb_wr_valid(wr_v), .o_fb_wr_fcs(wr_fcs), .o_receive_start_irq(irq),
    .o_rx_len_class(cls), .o_rx_frame_type(ftype), .o_rx_version(ver), .o_rx_dst_mode(dm),
    .o_rx_src_mode(sm), .o_rx_intra_pan(intra), .o_rx_ack_request(areq), .o_rx_end(rx_end),
    .o_rx_filter_pass(pass), .o_ack_send(ack), .o_ack_fcf(ack_fcf), .o_ack_seq(ack_seq));
  ffp_air_node air_u (
    .i_clk(clk), .i_air_data(air_d), .i_air_valid(air_v), .o_rx_data(rx_d),
    .o_rx_valid(rx_v), .o_air_ready(air_rdy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // frame buffer model: octet leaves once a read was taken
  always @(posedge clk) took <= rd_req;
  always @(negedge clk) begin
    if (took) void'(fbq.pop_front());
    fb_v = fbq.size() != 0;
    fb_d = fb_v ? fbq[0] : ~fb_d;
  end
  // event counters and run limit
  always @(posedge clk) begin
    cyc_n++;
    if (irq) irq_n++;
    if (irq) irq_d = wr_d;
    if (wr_fcs) fcs_n++;
    if (wr_v) wr_n++;
    if (rx_end) re_n++;
    if (ack) ack_n++;
    if (tx_end) te_n++;
    if (tx_end) wa = wait_ack;
    if (cyc_n > 5000) begin
      num_errors++;
      close_out();
    end
  end
  task close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // transmit one buffered frame and compare what went on the air
  task tx_run(input int extra_start);
    t0 = te_n;
    air_u.txq.delete();
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (20) @(negedge clk);
    start = extra_start[0];
    @(posedge clk);
    fbq.push_back(8'h00);
    fbq.push_back(8'h99);
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 2000 && te_n == t0; k++) @(negedge clk);
    `CHK(te_n - t0, 1)
    `CHK(busy, 1'b0)
    `CHK(air_u.txq.size(), exp_tx.size())
    for (k = 0; k < exp_tx.size(); k++) `CHK(air_u.txq[k], exp_tx[k])
  endtask
  initial begin
    {rstn, ama, arm, upl, start, fb_d} = '0;
    pend = 1'b1;
    sel = 2'h0;
    rows[0] = {16'h9861, 16'h1234, 4'b1001, 2'b11};
    rows[1] = {16'h9861, 16'hffff, 4'b1001, 2'b01};
    rows[2] = {16'h8400, 16'h1234, 4'b1000, 2'b01};
    rows[3] = {16'h8824, 16'h1234, 4'b1001, 2'b00};
    rows[4] = {16'h8825, 16'h1234, 4'b1101, 2'b01};
    rows[5] = {16'h9863, 16'h1234, 4'b1000, 2'b01};
    rows[6] = {16'h0823, 16'h1234, 4'b1000, 2'b11};
    rows[7] = {16'h9861, 16'h1234, 4'b0001, 2'b01};
    rows[8] = {16'h8827, 16'h1234, 4'b1000, 2'b00};
    rows[9] = {16'hcc21, 16'hffff, 4'b1000, 2'b11};
    repeat (4) @(negedge clk);
    `CHK({air_v, busy, rd_req, irq, ack, ack_fcf}, 21'h000000)
    rstn = 1'b1;
    for (r = 0; r < 10; r++) begin
      {fcf, da, ama, upl, sel, eack, epass} = rows[r];
      f = {8'h0a, fcf[7:0], fcf[15:8], 8'h40 + r[7:0], 8'h34, 8'h12, da[7:0], da[15:8],
           8'h04, 8'hee, 8'hee};
      {t0, k, a0, w0, e0} = {irq_n, fcs_n, ack_n, wr_n, re_n};
      air_u.send(f);
      repeat (2) @(negedge clk);
      `CHK(irq_n - t0, 1)
      `CHK(fcs_n - k, 2)
      `CHK(wr_n - w0, 11)
      `CHK(re_n - e0, 1)
      `CHK(cls, 2'h2)
      `CHK(ftype, fcf[2:0])
      `CHK({ver, dm, sm}, {fcf[13:12], fcf[11:10], fcf[15:14]})
      `CHK({intra, areq}, fcf[6:5])
      `CHK(pass, epass)
      `CHK(ack_n - a0, int'(eack))
      if (eack) `CHK({ack_fcf, ack_seq}, {(fcf[2:0] == 3'h3 && fcf[11:10] == 2'h2 &&
        fcf[15:14] == 2'h0) ? 16'h0012 : 16'h0002, 8'h40 + r[7:0]})
    end
    // data request acked with the pending setting cleared
    pend = 1'b0;
    f = {8'h0a, 8'h23, 8'h08, 8'h4a, 8'h34, 8'h12, 8'h34, 8'h12, 8'h04, 8'hee, 8'hee};
    a0 = ack_n;
    air_u.send(f);
    repeat (2) @(negedge clk);
    `CHK(ack_n - a0, 1)
    `CHK({ack_fcf, ack_seq}, 24'h00024a)
    $display("test frame rows done");
    t0 = irq_n;
    f = {8'h00};
    air_u.send(f);
    repeat (2) @(negedge clk);
    `CHK(irq_n - t0, 0)
    f = {8'h85, 8'h02, 8'h00, 8'h55, 8'hee, 8'hee};
    air_u.send(f);
    `CHK(irq_d, 8'h05)
    `CHK(cls, 2'h1)
    for (r = 3; r < 9; r += 4) begin
      f = {r[7:0], 8'h01, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
      f = f[0:r];
      air_u.send(f);
      `CHK(cls, 2'h0)
    end
    $display("test length octet done");
    arm = 1'b1;
    air_u.slow = 1'b1;
    fbq = {8'h83, 8'h21};
    exp_tx = {8'h00, 8'h00, 8'h00, 8'h00, 8'ha7, 8'h03, 8'h21, 8'h00, 8'h99};
    tx_run(1);
    `CHK(wa, 1'b1)
    air_u.slow = 1'b0;
    fbq = {8'h03, 8'h01};
    exp_tx[6] = 8'h01;
    tx_run(0);
    `CHK(wa, 1'b0)
    $display("test transmit done");
    close_out();
  end
endmodule
